// ===== core/eom_pkg.sv
package eom_pkg;
	// Register offsets
	localparam logic [7:0] EOM_OFS_POWER_RANGE = 8'h11;
	localparam logic [7:0] EOM_OFS_OVERRIDE = 8'h22;
	localparam logic [7:0] EOM_OFS_SWEEP = 8'h24;
	localparam logic [7:0] EOM_OFS_COUNT_UPPER = 8'h25;
	localparam logic [7:0] EOM_OFS_COUNT_LOWER = 8'h26;
	localparam logic [7:0] EOM_OFS_HORIZONTAL = 8'h27;
	localparam logic [7:0] EOM_OFS_VERTICAL = 8'h28;
	localparam logic [7:0] EOM_OFS_DWELL = 8'h2A;
	localparam logic [7:0] EOM_OFS_LOCK_CTRL = 8'h3E;
	localparam logic [7:0] EOM_OFS_LOCK_THRESH = 8'h6A;
	// Field positions
	localparam int EOM_BIT_RANGE_LO = 6;
	localparam int EOM_BIT_POWER_DOWN = 5;
	localparam int EOM_BIT_MONITOR_OVERRIDE = 7;
	localparam int EOM_BIT_FAST_MODE = 7;
	localparam int EOM_BIT_START = 0;
	localparam int EOM_BIT_LOCK_MON_EN = 7;
	// Reset values
	localparam logic EOM_RST_POWER_DOWN = 1'b1;
	localparam logic EOM_RST_LOCK_MON_EN = 1'b1;
	localparam logic [7:0] EOM_RST_DWELL = 8'h40;
	localparam logic [7:0] EOM_RST_LOCK_THRESH = 8'h44;
	// Grid and timing
	localparam int EOM_GRID_SIDE = 64;
	localparam logic [12:0] EOM_GRID_POINTS = 13'h1000;
	localparam logic [5:0] EOM_VOLT_MID = 6'h20;
	localparam logic [5:0] EOM_LAST_STEP = 6'h3F;
	localparam int EOM_DWELL_SHIFT = 10;
	localparam int EOM_SPAN_STEP_MV = 100;
	localparam int EOM_THRESH_SCALE = 2;
	localparam int EOM_FIFO_DEPTH = 8;
	localparam int EOM_COUNT_W = 16;
	// Sweep engine states
	typedef enum logic [3:0] {
		EOM_ST_IDLE = 4'h1,
		EOM_ST_GRID = 4'h2,
		EOM_ST_HSWEEP = 4'h4,
		EOM_ST_VSWEEP = 4'h8
	} eom_state_t;
endpackage

// ===== core/eom_count_if.sv
`timescale 1ns/100ps
interface eom_count_if;
	logic start;
	logic [7:0] dwell;
	logic done;
	logic [15:0] count;
	modport engine (output start, output dwell, input done, input count);
	modport counter (input start, input dwell, output done, output count);
endinterface

// ===== core/eom_fifo.sv
`timescale 1ns/100ps
module eom_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} eom_fifo_state_t;
	eom_fifo_state_t r;
	eom_fifo_state_t next_r;
	logic push;
	logic pop;
	assign in_ready_out = (r.cnt != (AW+1)'(DEPTH));
	assign out_valid_out = (r.cnt != '0);
	assign out_data_out = r.mem[r.rd];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wr] = in_data_in;
			next_r.wr = r.wr + 1'b1;
		end
		if (pop) begin
			next_r.rd = r.rd + 1'b1;
		end
		next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule

// ===== core/eom_point_counter.sv
`timescale 1ns/100ps
module eom_point_counter
	import eom_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Comparator decisions
	input wire logic sample_valid_in,
	input wire logic primary_bit_in,
	input wire logic offset_bit_in,
	// Engine side
	eom_count_if.counter cif
);
	typedef struct packed {
		logic busy;
		logic done;
		logic [18:0] samples;
		logic [15:0] count;
	} eom_cnt_state_t;
	eom_cnt_state_t r;
	eom_cnt_state_t next_r;
	logic [18:0] target;
	assign target = {(9'(cif.dwell) + 9'h001), 10'h000};
	assign cif.done = r.done;
	assign cif.count = r.count;
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		if (cif.start) begin
			next_r.busy = 1'b1;
			next_r.samples = '0;
			next_r.count = '0;
		end else if (r.busy && sample_valid_in) begin
			if ((primary_bit_in != offset_bit_in) && (r.count != 16'hFFFF)) begin
				next_r.count = r.count + 16'h0001;
			end
			next_r.samples = r.samples + 19'h00001;
			if (next_r.samples == target) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
		end
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule

// ===== core/eom_monitor.sv
`timescale 1ns/100ps
module eom_monitor
	import eom_pkg::*;
#(
	parameter int LOCK_CHECK_CYCLES = 100000
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	// Comparator decisions
	input wire logic sample_valid_in,
	input wire logic primary_bit_in,
	input wire logic offset_bit_in,
	// Lock state machine side
	input wire logic [1:0] cdr_range_in,
	output logic lock_lost_out,
	// Analog controls
	output logic monitor_power_out,
	output logic [5:0] phase_offset_out,
	output logic [5:0] voltage_offset_out,
	output logic [1:0] voltage_range_out,
	output logic [8:0] voltage_span_mv_out
);
	typedef struct packed {
		eom_state_t state;
		logic [1:0] range_code;
		logic power_down;
		logic monitor_override;
		logic fast;
		logic start;
		logic [7:0] dwell;
		logic lock_en;
		logic [7:0] thresh;
		logic [5:0] phase;
		logic [5:0] volt;
		logic cnt_start;
		logic busy;
		logic have_res;
		logic [15:0] res;
		logic adv_pend;
		logic [12:0] started;
		logic [15:0] hold;
		logic hold_valid;
		logic upper_read;
		logic [12:0] pairs;
		logic [7:0] horizontal_opening;
		logic [7:0] vertical_opening;
		logic [5:0] h_first;
		logic [5:0] h_last;
		logic h_seen;
		logic [6:0] open_cnt;
		logic [31:0] timer;
		logic lock_lost;
		logic power;
		logic [1:0] range_out;
		logic [8:0] span;
		logic [7:0] rdata;
	} eom_top_state_t;

	eom_top_state_t r;
	eom_top_state_t next_r;
	eom_count_if cif ();
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [15:0] fifo_out_data;
	logic start_req;
	logic pair_done;
	logic upper_begin;
	logic [6:0] centre_sum;
	logic [3:0] h_thresh;
	logic [3:0] v_thresh;

	assign cif.start = r.cnt_start;
	assign cif.dwell = r.dwell;
	assign h_thresh = r.thresh[7:4];
	assign v_thresh = r.thresh[3:0];
	assign centre_sum = 7'(r.h_first) + 7'(r.h_last);

	eom_point_counter u_counter (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.sample_valid_in(sample_valid_in),
		.primary_bit_in(primary_bit_in),
		.offset_bit_in(offset_bit_in),
		.cif(cif)
	);

	eom_fifo #(
		.WIDTH(EOM_COUNT_W),
		.DEPTH(EOM_FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.in_valid_in(r.have_res && (r.state == EOM_ST_GRID)),
		.in_ready_out(fifo_in_ready),
		.in_data_in(r.res),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(!r.hold_valid),
		.out_data_out(fifo_out_data)
	);

	always_comb begin
		next_r = r;
		next_r.cnt_start = 1'b0;
		next_r.lock_lost = 1'b0;
		start_req = 1'b0;
		pair_done = 1'b0;
		upper_begin = 1'b0;
		// Register writes
		if (reg_write_in) begin
			unique case (reg_addr_in)
				EOM_OFS_POWER_RANGE: begin
					next_r.range_code = reg_wdata_in[EOM_BIT_RANGE_LO+1:EOM_BIT_RANGE_LO];
					next_r.power_down = reg_wdata_in[EOM_BIT_POWER_DOWN];
				end
				EOM_OFS_OVERRIDE: begin
					next_r.monitor_override = reg_wdata_in[EOM_BIT_MONITOR_OVERRIDE];
				end
				EOM_OFS_SWEEP: begin
					next_r.fast = reg_wdata_in[EOM_BIT_FAST_MODE];
					start_req = reg_wdata_in[EOM_BIT_START] && reg_wdata_in[EOM_BIT_FAST_MODE];
				end
				EOM_OFS_DWELL: begin
					next_r.dwell = reg_wdata_in;
				end
				EOM_OFS_LOCK_CTRL: begin
					next_r.lock_en = reg_wdata_in[EOM_BIT_LOCK_MON_EN];
				end
				EOM_OFS_LOCK_THRESH: begin
					next_r.thresh = reg_wdata_in;
				end
				default: begin
				end
			endcase
		end
		// Register reads and their side effects
		if (reg_read_in) begin
			unique case (reg_addr_in)
				EOM_OFS_POWER_RANGE: begin
					next_r.rdata = {r.range_code, r.power_down, 5'h00};
				end
				EOM_OFS_OVERRIDE: begin
					next_r.rdata = {r.monitor_override, 7'h00};
				end
				EOM_OFS_SWEEP: begin
					next_r.rdata = {r.fast, 6'h00, r.start};
				end
				EOM_OFS_COUNT_UPPER: begin
					if (!r.upper_read) begin
						next_r.rdata = r.hold[15:8];
						upper_begin = 1'b1;
					end else begin
						next_r.rdata = r.hold[7:0];
						pair_done = 1'b1;
					end
				end
				EOM_OFS_COUNT_LOWER: begin
					next_r.rdata = r.hold[7:0];
					pair_done = r.upper_read;
				end
				EOM_OFS_HORIZONTAL: begin
					next_r.rdata = r.horizontal_opening;
				end
				EOM_OFS_VERTICAL: begin
					next_r.rdata = r.vertical_opening;
				end
				EOM_OFS_DWELL: begin
					next_r.rdata = r.dwell;
				end
				EOM_OFS_LOCK_CTRL: begin
					next_r.rdata = {r.lock_en, 7'h00};
				end
				EOM_OFS_LOCK_THRESH: begin
					next_r.rdata = r.thresh;
				end
				default: begin
					next_r.rdata = 8'h00;
				end
			endcase
		end
		// Result holding pair
		if (upper_begin) begin
			next_r.upper_read = 1'b1;
			if ((r.state == EOM_ST_GRID) && (r.started != EOM_GRID_POINTS)) begin
				next_r.adv_pend = 1'b1;
			end
		end
		if (pair_done) begin
			next_r.upper_read = 1'b0;
			next_r.hold_valid = 1'b0;
			if (r.state == EOM_ST_GRID) begin
				next_r.pairs = r.pairs + 13'h0001;
			end
		end else if (!r.hold_valid && fifo_out_valid) begin
			next_r.hold = fifo_out_data;
			next_r.hold_valid = 1'b1;
		end
		// Periodic lock check timer
		if (r.lock_en && (r.state == EOM_ST_IDLE)) begin
			if (r.timer == 32'(LOCK_CHECK_CYCLES - 1)) begin
				next_r.timer = '0;
			end else begin
				next_r.timer = r.timer + 32'h00000001;
			end
		end else begin
			next_r.timer = '0;
		end
		// Sweep engine
		unique case (r.state)
			EOM_ST_IDLE: begin
				if (r.lock_en && (r.timer == 32'(LOCK_CHECK_CYCLES - 1))) begin
					next_r.state = EOM_ST_HSWEEP;
					next_r.phase = '0;
					next_r.volt = EOM_VOLT_MID;
					next_r.open_cnt = '0;
					next_r.h_seen = 1'b0;
					next_r.h_first = '0;
					next_r.h_last = '0;
					next_r.cnt_start = 1'b1;
				end
			end
			EOM_ST_GRID: begin
				if (cif.done) begin
					next_r.busy = 1'b0;
					next_r.have_res = 1'b1;
					next_r.res = cif.count;
				end
				if (r.have_res && fifo_in_ready) begin
					next_r.have_res = cif.done;
				end
				if (r.adv_pend && !r.busy && !r.have_res && !r.cnt_start) begin
					{next_r.phase, next_r.volt} = {r.phase, r.volt} + 12'h001;
					next_r.started = r.started + 13'h0001;
					next_r.cnt_start = 1'b1;
					next_r.busy = 1'b1;
					next_r.adv_pend = 1'b0;
				end
				if (next_r.pairs == EOM_GRID_POINTS) begin
					next_r.start = 1'b0;
					next_r.state = EOM_ST_IDLE;
				end
			end
			EOM_ST_HSWEEP: begin
				if (cif.done) begin
					if (cif.count == 16'h0000) begin
						next_r.open_cnt = r.open_cnt + 7'h01;
						next_r.h_last = r.phase;
						if (!r.h_seen) begin
							next_r.h_first = r.phase;
							next_r.h_seen = 1'b1;
						end
					end
					if (r.phase == EOM_LAST_STEP) begin
						next_r.horizontal_opening = 8'(next_r.open_cnt);
						next_r.phase = centre_sum[6:1];
						if (cif.count == 16'h0000) begin
							next_r.phase = 6'((7'(r.h_seen ? r.h_first : r.phase) + 7'(r.phase)) >> 1);
						end
						next_r.volt = '0;
						next_r.open_cnt = '0;
						next_r.state = EOM_ST_VSWEEP;
					end else begin
						next_r.phase = r.phase + 6'h01;
					end
					next_r.cnt_start = 1'b1;
				end
			end
			EOM_ST_VSWEEP: begin
				if (cif.done) begin
					if (cif.count == 16'h0000) begin
						next_r.open_cnt = r.open_cnt + 7'h01;
					end
					if (r.volt == EOM_LAST_STEP) begin
						next_r.vertical_opening = 8'(next_r.open_cnt);
						next_r.state = EOM_ST_IDLE;
						if (({1'b0, next_r.open_cnt} < ({4'h0, v_thresh} << EOM_THRESH_SCALE)) ||
							(r.horizontal_opening < ({4'h0, h_thresh} << EOM_THRESH_SCALE))) begin
							next_r.lock_lost = r.lock_en;
						end
					end else begin
						next_r.volt = r.volt + 6'h01;
						next_r.cnt_start = 1'b1;
					end
				end
			end
			default: begin
				next_r.state = EOM_ST_IDLE;
			end
		endcase
		// Full sweep start takes over from any other activity
		if (start_req && !r.power_down && !r.monitor_override && (r.state != EOM_ST_GRID)) begin
			next_r.state = EOM_ST_GRID;
			next_r.start = 1'b1;
			next_r.phase = '0;
			next_r.volt = '0;
			next_r.started = 13'h0001;
			next_r.pairs = '0;
			next_r.adv_pend = 1'b0;
			next_r.have_res = 1'b0;
			next_r.busy = 1'b1;
			next_r.cnt_start = 1'b1;
			next_r.hold_valid = 1'b0;
			next_r.upper_read = 1'b0;
		end
		// Power and range outputs
		next_r.power = !next_r.power_down || (next_r.state != EOM_ST_IDLE);
		next_r.range_out = next_r.power_down ? cdr_range_in : next_r.range_code;
		next_r.span = 9'(EOM_SPAN_STEP_MV * (32'(next_r.range_out) + 1));
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r <= '0;
			r.state <= EOM_ST_IDLE;
			r.power_down <= EOM_RST_POWER_DOWN;
			r.lock_en <= EOM_RST_LOCK_MON_EN;
			r.dwell <= EOM_RST_DWELL;
			r.thresh <= EOM_RST_LOCK_THRESH;
			r.span <= 9'(EOM_SPAN_STEP_MV);
		end else begin
			r <= next_r;
		end
	end

	assign reg_rdata_out = r.rdata;
	assign lock_lost_out = r.lock_lost;
	assign monitor_power_out = r.power;
	assign phase_offset_out = r.phase;
	assign voltage_offset_out = r.volt;
	assign voltage_range_out = r.range_out;
	assign voltage_span_mv_out = r.span;
endmodule

// ===== sim/eom_monitor_assertions.sv
`timescale 1ns/100ps
module eom_monitor_checker
	import eom_pkg::*;
#(
	parameter int LOCK_CHECK_CYCLES = 100000
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	// Comparator and lock side
	input wire logic sample_valid_in,
	input wire logic primary_bit_in,
	input wire logic offset_bit_in,
	input wire logic [1:0] cdr_range_in,
	input wire logic lock_lost_out,
	// Analog controls
	input wire logic monitor_power_out,
	input wire logic [5:0] phase_offset_out,
	input wire logic [5:0] voltage_offset_out,
	input wire logic [1:0] voltage_range_out,
	input wire logic [8:0] voltage_span_mv_out
);
	// Shadow copies of written control bits
	logic pd_s;
	logic mon_s;
	logic [1:0] ovr_s;
	logic [7:0] dwell_s;
	logic [1:0] up;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pd_s <= EOM_RST_POWER_DOWN;
			mon_s <= EOM_RST_LOCK_MON_EN;
			ovr_s <= 2'h0;
			dwell_s <= EOM_RST_DWELL;
			up <= 2'h0;
		end else begin
			if (up != 2'h3) begin
				up <= up + 2'h1;
			end
			if (reg_write_in && reg_addr_in == EOM_OFS_POWER_RANGE) begin
				pd_s <= reg_wdata_in[5];
				ovr_s <= reg_wdata_in[7:6];
			end
			if (reg_write_in && reg_addr_in == EOM_OFS_LOCK_CTRL) begin
				mon_s <= reg_wdata_in[7];
			end
			if (reg_write_in && reg_addr_in == EOM_OFS_DWELL) begin
				dwell_s <= reg_wdata_in;
			end
		end
	end
	a_span_code: assert property (
		voltage_span_mv_out == 9'(voltage_range_out) * 9'h064 + 9'h064) else $error("span does not match range");
	a_range_source: assert property (
		up == 2'h3 |-> voltage_range_out == (pd_s ? $past(cdr_range_in) : ovr_s))
		else $error("range not from override or lock logic");
	a_power_range_read: assert property (
		reg_read_in && reg_addr_in == EOM_OFS_POWER_RANGE |=> reg_rdata_out == {ovr_s, pd_s, 5'h00})
		else $error("power and range readback wrong");
	a_dwell_read: assert property (
		reg_read_in && reg_addr_in == EOM_OFS_DWELL |=> reg_rdata_out == dwell_s) else $error("dwell readback wrong");
	a_lockctl_read: assert property (
		reg_read_in && reg_addr_in == EOM_OFS_LOCK_CTRL |=> reg_rdata_out == {mon_s, 7'h00})
		else $error("lock control readback wrong");
	a_lock_quiet: assert property (
		!mon_s && !$past(mon_s) |-> !lock_lost_out) else $error("lock loss while check disabled");
	a_rdata_hold: assert property (
		!$past(reg_read_in) |-> $stable(reg_rdata_out)) else $error("read data changed without a read");
	a_power_rise: assert property (
		$rose(monitor_power_out) |-> !pd_s || $past(mon_s)) else $error("monitor powered without cause");
endmodule
bind eom_monitor eom_monitor_checker #(.LOCK_CHECK_CYCLES(LOCK_CHECK_CYCLES)) chk_u (
	.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
	.sample_valid_in(sample_valid_in), .primary_bit_in(primary_bit_in), .offset_bit_in(offset_bit_in),
	.cdr_range_in(cdr_range_in), .lock_lost_out(lock_lost_out), .monitor_power_out(monitor_power_out),
	.phase_offset_out(phase_offset_out), .voltage_offset_out(voltage_offset_out),
	.voltage_range_out(voltage_range_out), .voltage_span_mv_out(voltage_span_mv_out));

// ===== sim/eom_comparator_model.sv
`timescale 1ns/100ps
module eom_comparator_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Voltage offset now applied
	input wire logic [5:0] volt_in,
	// Comparator decisions
	output logic valid_out,
	output logic primary_out,
	output logic offset_out
);
	logic [7:0] scnt;
	logic [4:0] lim;
	logic pat;
	logic err;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			scnt <= 8'h00;
			valid_out <= 1'b0;
		end else begin
			valid_out <= !valid_out;
			if (valid_out) begin
				scnt <= scnt + 8'h01;
			end
		end
	end
	// Error share is 5/16 per voltage step up to step 3, every sample from step 4 on; idle cycles always disagree
	always_comb begin
		lim = (volt_in < 6'h04) ? 5'(volt_in) * 5'h05 : 5'h10;
		pat = scnt[0] ^ scnt[5];
		err = {1'b0, scnt[3:0]} < lim;
		primary_out = valid_out ? pat : !pat;
		offset_out = valid_out ? (pat ^ err) : pat;
	end
endmodule

// ===== sim/test_eom_monitor.sv
`timescale 1ns/100ps
module test_eom_monitor
	import eom_pkg::*;
;
	logic clk_in = 1'b0;
	logic resetn_in;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr_en;
	logic rd_en;
	logic [7:0] rdata;
	logic valid;
	logic prim;
	logic offs;
	logic [1:0] cdr;
	logic power;
	logic lost;
	logic [5:0] phase;
	logic [5:0] volt;
	logic [1:0] range;
	logic [8:0] span;
	logic [7:0] d;
	int errors = 0;
	int check_count = 0;
	always #25 clk_in = !clk_in;
	eom_monitor #(.LOCK_CHECK_CYCLES(50)) dut_u (
		.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata), .sample_valid_in(valid),
		.primary_bit_in(prim), .offset_bit_in(offs), .cdr_range_in(cdr), .lock_lost_out(lost),
		.monitor_power_out(power), .phase_offset_out(phase), .voltage_offset_out(volt),
		.voltage_range_out(range), .voltage_span_mv_out(span));
	eom_comparator_model cmp_u (.clk_in(clk_in), .resetn_in(resetn_in), .volt_in(volt),
		.valid_out(valid), .primary_out(prim), .offset_out(offs));
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_in);
		addr = a;
		wdata = v;
		wr_en = 1'b1;
		@(negedge clk_in);
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk_in);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk_in);
		rd_en = 1'b0;
		d = rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		check({8'h00, d}, {8'h00, e});
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	initial begin
		repeat (40000) @(posedge clk_in);
		errors++;
		results();
	end
	initial begin
		resetn_in = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		cdr = 2'h1;
		repeat (6) @(negedge clk_in);
		resetn_in = 1'b1;
		check(16'(power), 16'h0000);
		rc(EOM_OFS_POWER_RANGE, 8'h20);
		rc(EOM_OFS_DWELL, 8'h40);
		rc(EOM_OFS_LOCK_CTRL, 8'h80);
		rc(EOM_OFS_LOCK_THRESH, 8'h44);
		rc(EOM_OFS_SWEEP, 8'h00);
		rc(8'h10, 8'h00);
		rc(EOM_OFS_HORIZONTAL, 8'h00);
		rc(EOM_OFS_VERTICAL, 8'h00);
		done("reset");
		idle(60);
		check(16'(power), 16'h0001);
		wr(EOM_OFS_LOCK_CTRL, 8'h00);
		rc(EOM_OFS_LOCK_CTRL, 8'h00);
		wr(EOM_OFS_LOCK_THRESH, 8'h5A);
		rc(EOM_OFS_LOCK_THRESH, 8'h5A);
		check(16'(lost), 16'h0000);
		done("lock");
		for (int c = 0; c < 4; c++) begin
			wr(EOM_OFS_POWER_RANGE, 8'(c << 6));
			idle(2);
			check(16'(range), 16'(c));
			check(16'(span), 16'((c + 1) * 100));
			rc(EOM_OFS_POWER_RANGE, 8'(c << 6));
		end
		wr(EOM_OFS_POWER_RANGE, 8'hE0);
		idle(2);
		check(16'(range), 16'(cdr));
		done("range");
		wr(EOM_OFS_SWEEP, 8'h81);
		rd(EOM_OFS_SWEEP);
		check(16'(d[0]), 16'h0000);
		wr(EOM_OFS_OVERRIDE, 8'h80);
		wr(EOM_OFS_POWER_RANGE, 8'hC0);
		wr(EOM_OFS_SWEEP, 8'h81);
		rd(EOM_OFS_SWEEP);
		check(16'(d[0]), 16'h0000);
		wr(EOM_OFS_OVERRIDE, 8'h00);
		wr(EOM_OFS_DWELL, 8'h00);
		rc(EOM_OFS_DWELL, 8'h00);
		done("refuse");
		wr(EOM_OFS_SWEEP, 8'h81);
		rc(EOM_OFS_SWEEP, 8'h81);
		check(16'(power), 16'h0001);
		idle(2200);
		rc(EOM_OFS_COUNT_UPPER, 8'h00);
		rc(EOM_OFS_COUNT_LOWER, 8'h00);
		idle(2200);
		rc(EOM_OFS_COUNT_UPPER, 8'h01);
		idle(4400);
		rc(EOM_OFS_COUNT_LOWER, 8'h40);
		rc(EOM_OFS_COUNT_UPPER, 8'h02);
		rc(EOM_OFS_COUNT_UPPER, 8'h80);
		idle(2200);
		rc(EOM_OFS_COUNT_UPPER, 8'h03);
		idle(3);
		check({4'h0, phase, volt}, 16'h0004);
		rc(EOM_OFS_COUNT_LOWER, 8'hC0);
		rc(EOM_OFS_SWEEP, 8'h81);
		done("grid");
		results();
	end
endmodule
